// *** hw/gsl_port_core.sv ***
// Four 8-bit ports with simultaneous capture, trapping and output update.
`timescale 1ns/1ns
// How it works
// [R1] Output pins drive the bytes written to the four output value words.
// [R2] After command E8h the read windows show the driven output values.
// [R3] All inputs are captured in one cycle by strobe, command or timer.
// [R4] Host enables strobe/command capture with mode D2, edge with D5.
// [R5] Capture stores filtered inputs on selected strobe edge or command EAh.
// [R6] Captured data holds until the next capture trigger replaces it.
// [R7] Enable bit D1 raises an interrupt on each selected input strobe edge.
// [R8] Mode command C8h captures if the strobe already sits at edge level.
// [R9] After a strobe capture further strobe edges are ignored 4 cycles.
// [R10] Host sets mode D3, enable D0, loads and starts timer for capture.
// [R11] Timer up to 32 s captures at time-out, once or continuously.
// [R12] Status D0 flags time-out; reading it as 1 releases the interrupt.
// [R13] After command E7h the read windows show the captured inputs.
// [R14] Two enable and two direction commands set trapping per input.
// [R15] An enabled input trap flag sets on its chosen edge and sticks.
// [R16] After command E9h the read windows show the trap flags.
// [R17] Reading a trap window clears its flags; a command clears all.
// [R18] Traps sample on the clock, so sub-cycle pulses may be missed.
// [R19] Host enables strobe/command update with mode D0, edge with D4.
// [R20] In simultaneous mode writes wait; all ports update on trigger.
// [R21] Enable bit D2 raises an interrupt on each selected output edge.
// [R22] Host writes command EBh to update the outputs by software.
// [R23] The interrupt request pin is open drain, pulled low when active.
// [R24] Read windows map to ports A to D; content follows last select.
// [R25] Both strobes pass a two-stage synchroniser before edge detection.
// [R26] Capture command and strobe edge in one cycle give one capture.
module gsl_port_core #(
  parameter int TMR_W = $clog2(`GSL_TMR_MAX_US + 1),
  parameter int LOCK_W = 3
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire gsl_pkg::gsl_wb_req_s wb_req,
  output gsl_pkg::gsl_wb_rsp_s wb_rsp,
  input wire logic [31:0] port_in,
  output logic [31:0] port_out,
  output logic [31:0] port_oe_n,
  input wire logic input_capture_strobe,
  input wire logic output_update_strobe,
  input wire logic interrupt_request_n_in,
  output logic interrupt_request_n_out,
  output logic interrupt_request_n_oe_n
);
  import gsl_pkg::*;

  localparam int PW = `GSL_PORT_W;
  localparam logic [6:0] US_LAST = 7'(`GSL_US_CYCLES - 1);
  localparam logic [LOCK_W-1:0] LOCK_LOAD = LOCK_W'(`GSL_LOCK_CYC);

  // --------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------
  function automatic logic grp_hit(input logic [`GSL_ADR_W-1:0] a,
                                   input logic [`GSL_ADR_W-1:0] base);
    grp_hit = (a[`GSL_ADR_W-1:4] == base[`GSL_ADR_W-1:4]) &&
              (a[1:0] == 2'h0);
  endfunction : grp_hit

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[i*PW +: PW] = dat[i*PW +: PW];
      end
    end
  endfunction : merge

  // --------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------
  logic [31:0] pin_s1, pin_s2, pin_d;
  logic [2:0] ist_s, ost_s;
  logic [1:0] irq_s;

  // [R25] Strobes and pins pass two flops before any logic.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= `GSL_RST_WORD;
      pin_s2 <= `GSL_RST_WORD;
      pin_d <= `GSL_RST_WORD;
      ist_s <= 3'h0;
      ost_s <= 3'h0;
      irq_s <= 2'h3;
    end else begin
      pin_s1 <= port_in;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
      ist_s <= {ist_s[1:0], input_capture_strobe};
      ost_s <= {ost_s[1:0], output_update_strobe};
      irq_s <= {irq_s[0], interrupt_request_n_in};
    end
  end

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  gsl_mode_s mode_pend_reg, mode_pend_next, mode_act_reg, mode_act_next;
  gsl_irq_s ien_pend_reg, ien_pend_next, ien_act_reg, ien_act_next;
  gsl_irq_s istat_reg, istat_next;
  gsl_disp_e disp_reg, disp_next;
  gsl_tmr_e tmr_reg, tmr_next;
  logic [6:0] presc_reg, presc_next;
  logic [TMR_W-1:0] tval_reg, tval_next, tcnt_reg, tcnt_next;
  logic [LOCK_W-1:0] lock_reg, lock_next;
  logic [31:0] out_reg, out_next, pin_reg, pin_next, cap_reg, cap_next;
  logic [31:0] dir_reg, dir_next, ten_reg, ten_next, tdir_reg, tdir_next;
  logic [31:0] trap_reg, trap_next, tdata_reg, tdata_next;

  logic take, wr, rd, cmd_v, tmo, ist_ok, ost_ok, cap_fire, upd, c8_lvl;
  logic [7:0] cmd;
  logic [1:0] idx;
  logic [`GSL_ADR_W-1:0] adr;
  logic [31:0] hit, clr, in_mask;
  logic [TMR_W-1:0] tlim;

  always_comb begin
    ack_next = 1'b0;
    rdat_next = rdat_reg;
    mode_pend_next = mode_pend_reg;
    mode_act_next = mode_act_reg;
    ien_pend_next = ien_pend_reg;
    ien_act_next = ien_act_reg;
    disp_next = disp_reg;
    tmr_next = tmr_reg;
    presc_next = 7'h00;
    tcnt_next = tcnt_reg;
    tval_next = tval_reg;
    lock_next = lock_reg;
    out_next = out_reg;
    pin_next = pin_reg;
    dir_next = dir_reg;
    ten_next = ten_reg;
    tdir_next = tdir_reg;
    tdata_next = tdata_reg;
    tmo = 1'b0;
    clr = 32'h0000_0000;
    adr = wb_req.adr;
    idx = adr[3:2];
    take = wb_req.cyc && wb_req.stb && !ack_reg;
    wr = take && wb_req.we;
    rd = take && !wb_req.we;
    cmd_v = wr && (adr == `GSL_OFS_CMD) && wb_req.sel[0];
    cmd = cmd_v ? 8'(wb_req.dat) : 8'h00;
    in_mask = pin_s2 & ~dir_reg;

    // Bus slave: every access, mapped or not, is acked one cycle later.
    ack_next = take;
    if (wr) begin
      case (adr)
        `GSL_OFS_MODE: begin
          mode_pend_next = gsl_mode_s'(wb_req.dat);
        end
        `GSL_OFS_IEN: begin
          ien_pend_next = gsl_irq_s'(wb_req.dat);
        end
        `GSL_OFS_TMR: begin
          tval_next = TMR_W'(merge(32'(tval_reg), wb_req.dat, wb_req.sel));
        end
        `GSL_OFS_TDATA: begin
          tdata_next = merge(tdata_reg, wb_req.dat, wb_req.sel);
        end
        `GSL_OFS_DIR: begin
          dir_next = merge(dir_reg, wb_req.dat, wb_req.sel);
        end
        default: begin
          if (grp_hit(adr, `GSL_OFS_OUT) && wb_req.sel[0]) begin
            out_next[idx*PW +: PW] = 8'(wb_req.dat);
            // [R20] Direct pin write only outside simultaneous mode.
            if (!mode_act_reg.out_sim) begin
              // [R1] Written byte reaches the pins.
              pin_next[idx*PW +: PW] = 8'(wb_req.dat);
            end
          end
        end
      endcase
    end

    // Command decode.
    case (cmd)
      `GSL_CMD_MODE: begin
        mode_act_next = mode_pend_reg;
        ien_act_next = ien_pend_reg;
      end
      // [R24] Display select steers all four windows.
      `GSL_CMD_SHOW_LIVE: disp_next = GSL_DISP_LIVE;
      `GSL_CMD_SHOW_LATCH: disp_next = GSL_DISP_LATCH;
      `GSL_CMD_SHOW_OUT: disp_next = GSL_DISP_OUT;
      `GSL_CMD_SHOW_TRAP: disp_next = GSL_DISP_TRAP;
      // [R17] One command clears all trap flags.
      `GSL_CMD_TRAP_CLR: clr = 32'hFFFF_FFFF;
      // [R14] Pair-wise enable and direction loads.
      `GSL_CMD_TRAP_EN_AB: ten_next[15:0] = 16'(tdata_reg);
      `GSL_CMD_TRAP_EN_CD: ten_next[31:16] = 16'(tdata_reg);
      `GSL_CMD_TRAP_DIR_AB: tdir_next[15:0] = 16'(tdata_reg);
      `GSL_CMD_TRAP_DIR_CD: tdir_next[31:16] = 16'(tdata_reg);
      default: begin
      end
    endcase

    // [R11] Timer counts microseconds up to the loaded value.
    tlim = (tval_reg == '0) ? TMR_W'(1) : tval_reg;
    if (tmr_reg != GSL_TMR_IDLE) begin
      presc_next = (presc_reg == US_LAST) ? 7'h00 : 7'(presc_reg + 7'h01);
      if (presc_reg == US_LAST) begin
        if (TMR_W'(tcnt_reg + 1'b1) >= tlim) begin
          tmo = 1'b1;
          tcnt_next = '0;
          if (tmr_reg == GSL_TMR_SINGLE) begin
            tmr_next = GSL_TMR_IDLE;
          end
        end else begin
          tcnt_next = TMR_W'(tcnt_reg + 1'b1);
        end
      end
    end
    case (cmd)
      `GSL_CMD_TMR_SINGLE, `GSL_CMD_TMR_CONT: begin
        tmr_next = (cmd == `GSL_CMD_TMR_CONT) ? GSL_TMR_CONT
                                               : GSL_TMR_SINGLE;
        tcnt_next = '0;
        presc_next = 7'h00;
      end
      `GSL_CMD_TMR_STOP: tmr_next = GSL_TMR_IDLE;
      `GSL_CMD_TMR_CYC_STOP: begin
        if (tmr_reg == GSL_TMR_CONT) begin
          tmr_next = GSL_TMR_SINGLE;
        end
      end
      default: begin
      end
    endcase

    // [R9] Input strobe edges are ignored while the lockout runs.
    ist_ok = (mode_act_reg.in_fall ? (!ist_s[1] && ist_s[2])
                                   : (ist_s[1] && !ist_s[2])) &&
             (lock_reg == '0);
    ost_ok = mode_act_reg.out_fall ? (!ost_s[1] && ost_s[2])
                                   : (ost_s[1] && !ost_s[2]);
    lock_next = (lock_reg == '0) ? lock_reg : LOCK_W'(lock_reg - 1'b1);
    if (mode_act_reg.in_sim && ist_ok) begin
      lock_next = LOCK_LOAD;
    end

    // [R8] Mode write with the strobe already at the edge's end level.
    c8_lvl = (cmd == `GSL_CMD_MODE) && mode_pend_reg.in_sim &&
             (ist_s[1] == !mode_pend_reg.in_fall);
    // [R26] All triggers merge into one capture.
    cap_fire = (mode_act_reg.in_sim &&
                (ist_ok || cmd == `GSL_CMD_CAPTURE)) ||
               (mode_act_reg.in_tmr && tmo) || c8_lvl;
    // [R3] [R5] [R6] Every input byte is taken in the same cycle.
    cap_next = cap_fire ? in_mask : cap_reg;

    // [R20] [R22] Staged words reach all pins together.
    upd = (mode_act_reg.out_sim && (ost_ok || cmd == `GSL_CMD_UPDATE)) ||
          (mode_act_reg.out_tmr && tmo);
    if (upd) begin
      pin_next = out_next;
    end

    // Read answers and read side effects.
    if (rd) begin
      case (adr)
        `GSL_OFS_CMD: rdat_next = 32'({tmr_reg, disp_reg});
        `GSL_OFS_MODE: rdat_next = 32'(mode_pend_reg);
        `GSL_OFS_IEN: rdat_next = 32'(ien_pend_reg);
        `GSL_OFS_ISTAT: rdat_next = 32'({irq_s[1], 3'h0, istat_reg});
        `GSL_OFS_TMR: rdat_next = 32'(tval_reg);
        `GSL_OFS_TDATA: rdat_next = tdata_reg;
        `GSL_OFS_DIR: rdat_next = dir_reg;
        default: begin
          rdat_next = `GSL_RST_WORD;
          if (grp_hit(adr, `GSL_OFS_OUT)) begin
            rdat_next = 32'(out_reg[idx*PW +: PW]);
          end else if (grp_hit(adr, `GSL_OFS_WIN)) begin
            // [R2] [R13] [R16] [R24] Window content by display select.
            case (disp_reg)
              GSL_DISP_LATCH: rdat_next = 32'(cap_reg[idx*PW +: PW]);
              GSL_DISP_OUT: rdat_next = 32'(pin_reg[idx*PW +: PW]);
              GSL_DISP_TRAP: rdat_next = 32'(trap_reg[idx*PW +: PW]);
              default: rdat_next = 32'(pin_s2[idx*PW +: PW]);
            endcase
            // [R17] Reading a trap window clears that byte.
            if (disp_reg == GSL_DISP_TRAP) begin
              clr[idx*PW +: PW] = 8'hFF;
            end
          end
        end
      endcase
    end

    // [R15] [R18] Clocked edge test; a new hit wins over a clear.
    hit = ten_reg & ~dir_reg &
          ((pin_s2 & ~pin_d & ~tdir_reg) | (~pin_s2 & pin_d & tdir_reg));
    trap_next = (trap_reg & ~clr) | hit;

    // [R7] [R12] [R21] Sticky status; read-as-one clears, set wins.
    istat_next = istat_reg;
    if (rd && adr == `GSL_OFS_ISTAT) begin
      istat_next = gsl_irq_s'(istat_reg & ~istat_reg);
    end
    istat_next.tmr = istat_next.tmr | (ien_act_reg.tmr & tmo);
    istat_next.in_stb = istat_next.in_stb | (ien_act_reg.in_stb & ist_ok);
    istat_next.out_stb = istat_next.out_stb |
                         (ien_act_reg.out_stb & ost_ok);
    istat_next.trap = istat_next.trap | (ien_act_reg.trap & (|hit));
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      rdat_reg <= `GSL_RST_WORD;
      mode_pend_reg <= '0;
      mode_act_reg <= '0;
      ien_pend_reg <= '0;
      ien_act_reg <= '0;
      istat_reg <= '0;
      disp_reg <= GSL_DISP_LIVE;
      tmr_reg <= GSL_TMR_IDLE;
      presc_reg <= 7'h00;
      tval_reg <= '0;
      tcnt_reg <= '0;
      lock_reg <= '0;
      out_reg <= `GSL_RST_WORD;
      pin_reg <= `GSL_RST_WORD;
      cap_reg <= `GSL_RST_WORD;
      dir_reg <= `GSL_RST_WORD;
      ten_reg <= `GSL_RST_WORD;
      tdir_reg <= `GSL_RST_WORD;
      trap_reg <= `GSL_RST_WORD;
      tdata_reg <= `GSL_RST_WORD;
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      mode_pend_reg <= mode_pend_next;
      mode_act_reg <= mode_act_next;
      ien_pend_reg <= ien_pend_next;
      ien_act_reg <= ien_act_next;
      istat_reg <= istat_next;
      disp_reg <= disp_next;
      tmr_reg <= tmr_next;
      presc_reg <= presc_next;
      tval_reg <= tval_next;
      tcnt_reg <= tcnt_next;
      lock_reg <= lock_next;
      out_reg <= out_next;
      pin_reg <= pin_next;
      cap_reg <= cap_next;
      dir_reg <= dir_next;
      ten_reg <= ten_next;
      tdir_reg <= tdir_next;
      trap_reg <= trap_next;
      tdata_reg <= tdata_next;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign wb_rsp.ack = ack_reg;
  assign wb_rsp.dat = rdat_reg;
  assign port_out = pin_reg;
  // Enable is low on bits configured as outputs.
  assign port_oe_n = ~dir_reg;
  // [R23] Open drain: only ever pulls low, released otherwise.
  assign interrupt_request_n_out = 1'b0;
  assign interrupt_request_n_oe_n = ~(|istat_reg);

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_strobe_cap;
    mode_act_reg.in_sim && ist_ok;
  endsequence

  sequence s_lock_run;
    (lock_reg != '0) [*4];
  endsequence

  a_cap_hold: assert property (!cap_fire |=> $stable(cap_reg)) // [R6]
    else $error("captured data changed without a trigger");

  a_cap_cmd: assert property ( // [R5]
    mode_act_reg.in_sim && cmd == `GSL_CMD_CAPTURE
    |=> cap_reg == $past(in_mask))
    else $error("capture command did not store the inputs");

  a_lock_hold: assert property ( // [R9]
    s_strobe_cap |=> s_lock_run ##1 (lock_reg == '0))
    else $error("strobe lockout length wrong");

  a_out_held: assert property ( // [R20]
    mode_act_reg.out_sim && !upd |=> $stable(pin_reg))
    else $error("pins moved while updates are held");

  a_out_direct: assert property ( // [R1]
    wr && !mode_act_reg.out_sim && adr == `GSL_OFS_OUT && wb_req.sel[0]
    |=> pin_reg[PW-1:0] == $past(wb_req.dat[PW-1:0]))
    else $error("port A write did not reach the pins");

  a_irq_release: assert property ( // [R12]
    rd && adr == `GSL_OFS_ISTAT && istat_reg.tmr && !tmo
    |=> !istat_reg.tmr)
    else $error("timer status not cleared by read");

  a_trap_sticky: assert property ( // [R15]
    (trap_reg & ~clr) != '0 |=> ($past(trap_reg & ~clr) & ~trap_reg) == '0)
    else $error("trap flag lost without a clear");

  a_tmr_single: assert property ( // [R11]
    tmo && tmr_reg == GSL_TMR_SINGLE && cmd_v == 1'b0
    |=> tmr_reg == GSL_TMR_IDLE)
    else $error("single timer did not stop after time-out");

  a_trap_window: assert property ( // [R16]
    rd && disp_reg == GSL_DISP_TRAP && grp_hit(adr, `GSL_OFS_WIN)
    |=> wb_rsp.ack && wb_rsp.dat == 32'($past(trap_reg[idx*PW +: PW])))
    else $error("trap window returned wrong data");

  a_input_capture_strobe_irq: assert property ( // [R7]
    ien_act_reg.in_stb && ist_ok |=> istat_reg.in_stb ##1 1'b1)
    else $error("input strobe interrupt not raised");

  a_irq_pin: assert property ( // [R23]
    $rose(istat_reg.out_stb) |-> !interrupt_request_n_oe_n)
    else $error("interrupt pin not pulled low");

endmodule : gsl_port_core

// *** hw/gsl_defs.svh ***
// Address map, command codes and timing constants of the port block.
`ifndef GSL_DEFS_SVH
`define GSL_DEFS_SVH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define GSL_ADR_W 8
`define GSL_PORT_W 8
`define GSL_NPORT 4

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define GSL_OFS_CMD 8'h00
`define GSL_OFS_MODE 8'h04
`define GSL_OFS_IEN 8'h08
`define GSL_OFS_ISTAT 8'h0C
`define GSL_OFS_OUT 8'h10
`define GSL_OFS_WIN 8'h20
`define GSL_OFS_TMR 8'h30
`define GSL_OFS_TDATA 8'h34
`define GSL_OFS_DIR 8'h38

// ----------------------------------------------------------------------
// Command codes written to the command word
// ----------------------------------------------------------------------
`define GSL_CMD_MODE 8'hC8
`define GSL_CMD_SHOW_LIVE 8'hE6
`define GSL_CMD_SHOW_LATCH 8'hE7
`define GSL_CMD_SHOW_OUT 8'hE8
`define GSL_CMD_SHOW_TRAP 8'hE9
`define GSL_CMD_CAPTURE 8'hEA
`define GSL_CMD_UPDATE 8'hEB
`define GSL_CMD_TRAP_CLR 8'hE4
`define GSL_CMD_TMR_SINGLE 8'hD0
`define GSL_CMD_TMR_CONT 8'hD1
`define GSL_CMD_TMR_STOP 8'hD2
`define GSL_CMD_TMR_CYC_STOP 8'hD3
`define GSL_CMD_TRAP_EN_AB 8'hB0
`define GSL_CMD_TRAP_EN_CD 8'hB1
`define GSL_CMD_TRAP_DIR_AB 8'hB2
`define GSL_CMD_TRAP_DIR_CD 8'hB3

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define GSL_RST_WORD 32'h0000_0000
`define GSL_CLK_PERIOD_NS 8
`define GSL_US_NS 1000
`define GSL_US_CYCLES (`GSL_US_NS / `GSL_CLK_PERIOD_NS)
`define GSL_TMR_MAX_US 32000000
`define GSL_LOCK_CYC 4

`endif

// *** hw/gsl_pkg.sv ***
// Types shared by the port block and its bench.
package gsl_pkg;
`include "gsl_defs.svh"

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [`GSL_ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } gsl_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } gsl_wb_rsp_s;

  // Mode word, bit 5 down to bit 0.
  typedef struct packed {
    logic in_fall;
    logic out_fall;
    logic in_tmr;
    logic in_sim;
    logic out_tmr;
    logic out_sim;
  } gsl_mode_s;

  // Interrupt enable and status words, bit 3 down to bit 0.
  typedef struct packed {
    logic trap;
    logic out_stb;
    logic in_stb;
    logic tmr;
  } gsl_irq_s;

  typedef enum logic [1:0] {
    GSL_TMR_IDLE = 2'b00,
    GSL_TMR_SINGLE = 2'b01,
    GSL_TMR_CONT = 2'b11
  } gsl_tmr_e;

  typedef enum logic [1:0] {
    GSL_DISP_LIVE = 2'b00,
    GSL_DISP_LATCH = 2'b01,
    GSL_DISP_OUT = 2'b11,
    GSL_DISP_TRAP = 2'b10
  } gsl_disp_e;

endpackage : gsl_pkg

// *** bench/gsl_far_side.sv ***
// Pin-side model: input pins, both strobes and the pulled-up request line.
`timescale 1ns/1ns
module gsl_far_side (
  input wire logic core_clk,
  input wire logic [31:0] port_out,
  input wire logic [31:0] port_oe_n,
  input wire logic irq_out,
  input wire logic irq_oe_n,
  output logic [31:0] port_in,
  output logic in_stb = 1'b0,
  output logic out_stb = 1'b0,
  output logic irq_line
);
  logic [31:0] pins = 32'h0000_0000;
  // Output-configured pins read back what the block drives.
  assign port_in = (port_out & ~port_oe_n) | (pins & port_oe_n);
  assign irq_line = irq_oe_n ? 1'b1 : irq_out;

  task automatic set_pins(input logic [31:0] v);
    @(posedge core_clk);
    pins <= v;
  endtask : set_pins

  // Holds the input strobe at a level until told otherwise.
  task automatic hold_in(input logic v);
    @(posedge core_clk);
    in_stb <= v;
  endtask : hold_in

  // Each level is held at least one clock so the synchroniser sees it.
  task automatic strobe(input logic sel_out);
    @(posedge core_clk);
    if (sel_out) out_stb <= 1'b1;
    else in_stb <= 1'b1;
    repeat (3) @(posedge core_clk);
    out_stb <= 1'b0;
    in_stb <= 1'b0;
  endtask : strobe

  // Second rising edge two cycles after the first, with new pin data.
  task automatic twin_pulse(input logic [31:0] late);
    @(posedge core_clk);
    in_stb <= 1'b1;
    @(posedge core_clk);
    in_stb <= 1'b0;
    @(posedge core_clk);
    in_stb <= 1'b1;
    pins <= late;
    repeat (2) @(posedge core_clk);
    in_stb <= 1'b0;
  endtask : twin_pulse
endmodule : gsl_far_side

// *** bench/gsl_port_core_tb.sv ***
// Self-checking bench for the synchronous port block.
`timescale 1ns/1ns
`include "gsl_defs.svh"
module gsl_port_core_tb;
  import gsl_pkg::*;
  typedef struct packed {
    logic we;
    logic [7:0] adr;
    logic [31:0] dat;
  } gsl_row_s;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  gsl_wb_req_s wb_req = '0;
  gsl_wb_rsp_s wb_rsp;
  logic [31:0] port_in;
  logic [31:0] port_out;
  logic [31:0] port_oe_n;
  logic in_stb;
  logic out_stb;
  logic irq_out;
  logic irq_oe_n;
  logic irq_line;
  logic [31:0] rd;
  logic [3:0] sel_w = 4'hF;
  int n_mismatch = 0;
  int n_checks = 0;
  int n;
  gsl_row_s rows [9] = '{
    '{1'b1, 8'h38, 32'h0000_FFFF}, '{1'b1, 8'h10, 32'h0000_0011},
    '{1'b1, 8'h14, 32'h0000_0022}, '{1'b1, 8'h00, 32'h0000_00E8},
    '{1'b0, 8'h20, 32'h0000_0011}, '{1'b0, 8'h24, 32'h0000_0022},
    '{1'b0, 8'h40, 32'h0000_0000}, '{1'b1, 8'h40, 32'hDEAD_BEEF},
    '{1'b0, 8'h40, 32'h0000_0000}};

  always #(`GSL_CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  gsl_port_core dut (
    .core_clk(core_clk), .resetn(resetn), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .port_in(port_in), .port_out(port_out), .port_oe_n(port_oe_n),
    .input_capture_strobe(in_stb), .output_update_strobe(out_stb),
    .interrupt_request_n_in(irq_line), .interrupt_request_n_out(irq_out),
    .interrupt_request_n_oe_n(irq_oe_n));

  gsl_far_side far (
    .core_clk(core_clk), .port_out(port_out), .port_oe_n(port_oe_n),
    .irq_out(irq_out), .irq_oe_n(irq_oe_n), .port_in(port_in),
    .in_stb(in_stb), .out_stb(out_stb), .irq_line(irq_line));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // The bus request is held until ack is sampled high at an edge.
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge core_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel_w, dat: dat};
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_rsp.ack !== 1'b1 && k < 32);
    chk({31'h0, wb_rsp.ack}, 32'h1);
    rd = wb_rsp.dat;
    wb_req <= '0;
    @(posedge core_clk);
  endtask : wb_xfer

  task automatic cmd(input logic [7:0] code);
    wb_xfer(1'b1, `GSL_OFS_CMD, {24'h0, code});
  endtask : cmd

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0);
    chk(rd & ((adr == `GSL_OFS_ISTAT) ? 32'h0F : 32'hFF), exp);
  endtask : rd_chk

  task automatic setup(input logic [7:0] mode, input logic [7:0] ien);
    wb_xfer(1'b1, `GSL_OFS_MODE, {24'h0, mode});
    wb_xfer(1'b1, `GSL_OFS_IEN, {24'h0, ien});
    cmd(`GSL_CMD_MODE);
  endtask : setup

  task automatic summarize();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  initial begin : watchdog
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end

  initial begin : main
    repeat (20) @(posedge core_clk);
    chk(port_oe_n & {32{irq_oe_n}}, 32'hFFFF_FFFF);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      wb_xfer(rows[i].we, rows[i].adr, rows[i].dat);
      if (!rows[i].we) chk(rd, rows[i].dat);
    end
    chk({16'h0, port_out[15:0]}, 32'h0000_2211);
    setup(8'h04, 8'h02);
    far.set_pins(32'hA5C3_0000);
    repeat (4) @(posedge core_clk);
    cmd(`GSL_CMD_CAPTURE);
    cmd(`GSL_CMD_SHOW_LATCH);
    rd_chk(8'h20, 32'h00);
    rd_chk(8'h28, 32'hC3);
    rd_chk(8'h2C, 32'hA5);
    far.set_pins(32'h3C5A_0000);
    repeat (8) @(posedge core_clk);
    rd_chk(8'h28, 32'hC3);
    far.strobe(1'b0);
    repeat (8) @(posedge core_clk);
    chk({31'h0, irq_line}, 32'h0);
    rd_chk(8'h2C, 32'h3C);
    rd_chk(`GSL_OFS_ISTAT, 32'h02);
    far.set_pins(32'h7100_0000);
    repeat (4) @(posedge core_clk);
    far.twin_pulse(32'h6600_0000);
    repeat (8) @(posedge core_clk);
    rd_chk(8'h2C, 32'h71);
    rd_chk(`GSL_OFS_ISTAT, 32'h02);
    // Simultaneous output on the rising edge.
    setup(8'h01, 8'h04);
    wb_xfer(1'b1, `GSL_OFS_OUT, 32'h5A);
    repeat (4) @(posedge core_clk);
    chk({24'h0, port_out[7:0]}, 32'h11);
    cmd(`GSL_CMD_UPDATE);
    repeat (2) @(posedge core_clk);
    chk({24'h0, port_out[7:0]}, 32'h5A);
    wb_xfer(1'b1, 8'h14, 32'h77);
    far.strobe(1'b1);
    repeat (8) @(posedge core_clk);
    chk({16'h0, port_out[15:0]}, 32'h775A);
    chk({31'h0, irq_line}, 32'h0);
    rd_chk(`GSL_OFS_ISTAT, 32'h04);
    setup(8'h08, 8'h01);
    wb_xfer(1'b1, `GSL_OFS_TMR, 32'h2);
    far.set_pins(32'h9900_0000);
    cmd(`GSL_CMD_TMR_SINGLE);
    n = 0;
    while (irq_line !== 1'b0 && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, n > 200 && n < 320}, 32'h1);
    rd_chk(`GSL_OFS_ISTAT, 32'h01);
    repeat (4) @(posedge core_clk);
    chk({31'h0, irq_line}, 32'h1);
    cmd(`GSL_CMD_SHOW_LATCH);
    rd_chk(8'h2C, 32'h99);
    repeat (600) @(posedge core_clk);
    chk({31'h0, irq_line}, 32'h1);
    // A mode command with the strobe already high captures.
    far.set_pins(32'h4200_0000);
    far.hold_in(1'b1);
    repeat (4) @(posedge core_clk);
    setup(8'h04, 8'h00);
    cmd(`GSL_CMD_SHOW_LATCH);
    rd_chk(8'h2C, 32'h42);
    far.hold_in(1'b0);
    far.set_pins(32'h0000_0000);
    wb_xfer(1'b1, `GSL_OFS_TDATA, 32'h00FF);
    cmd(`GSL_CMD_TRAP_EN_CD);
    far.set_pins(32'h000F_0000);
    repeat (4) @(posedge core_clk);
    far.set_pins(32'h0000_0000);
    repeat (4) @(posedge core_clk);
    cmd(`GSL_CMD_SHOW_TRAP);
    rd_chk(8'h28, 32'h0F);
    rd_chk(8'h28, 32'h00);
    far.set_pins(32'h00F0_0000);
    repeat (6) @(posedge core_clk);
    cmd(`GSL_CMD_TRAP_CLR);
    rd_chk(8'h28, 32'h00);
    cmd(`GSL_CMD_TRAP_DIR_CD);
    far.set_pins(32'h0000_0000);
    repeat (6) @(posedge core_clk);
    rd_chk(8'h28, 32'hF0);
    // Only byte lane 0 of the command word carries a command.
    sel_w = 4'h2;
    cmd(`GSL_CMD_SHOW_LIVE);
    wb_xfer(1'b1, `GSL_OFS_TDATA, 32'h1234_5678);
    sel_w = 4'hF;
    wb_xfer(1'b0, `GSL_OFS_TDATA, 32'h0);
    chk(rd, 32'h0000_56FF);
    rd_chk(`GSL_OFS_CMD, 32'h02);
    // A reset in mid-run returns every pin to an input.
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(port_out | ~port_oe_n, 32'h0000_0000);
    chk({31'h0, irq_line}, 32'h1);
    resetn <= 1'b1;
    rd_chk(`GSL_OFS_CMD, 32'h00);
    summarize();
  end
endmodule : gsl_port_core_tb
